// [logic/pgp_pkg.sv]
// Purpose: shared constants for the analog port gpio and edge flag block
// Assumes: axi4-lite slave with 32-bit data, byte address = 4 * register index
// Notes: port registers are 8 bits wide, edge registers 2 bits (bits 7 and 6); all sit in the low byte of a word
package pgp_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PORT_W = 8;
    localparam int EDGE_W = 2;

    // register indices; byte address is index * 4
    localparam logic [5:0] IDX_EDGE_POLARITY = 6'h2D;
    localparam logic [5:0] IDX_EDGE_IRQ_EN = 6'h2E;
    localparam logic [5:0] IDX_EDGE_FLAG = 6'h2F;
    localparam logic [5:0] IDX_PORT_DATA = 6'h30;
    localparam logic [5:0] IDX_PIN_LEVEL = 6'h31;
    localparam logic [5:0] IDX_DIRECTION = 6'h32;
    localparam logic [5:0] IDX_DRIVE = 6'h33;
    localparam logic [5:0] IDX_PULL_EN = 6'h34;
    localparam logic [5:0] IDX_PULL_POL = 6'h35;

    // word select lives above the two byte-offset bits
    localparam int IDX_LSB = 2;

    // edge pins occupy bits 7 and 6 of their registers
    localparam int EDGE_LSB = 6;

    localparam logic [PORT_W-1:0] RST_BYTE = 8'h00;
    localparam logic [EDGE_W-1:0] RST_EDGE = 2'b00;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // register decode result
    typedef enum logic [3:0] {
        SEL_NONE = 4'h0,
        SEL_EPOL = 4'h1,
        SEL_EIEN = 4'h2,
        SEL_EFLG = 4'h3,
        SEL_DATA = 4'h4,
        SEL_PINL = 4'h5,
        SEL_DIR = 4'h6,
        SEL_DRV = 4'h7,
        SEL_PEN = 4'h8,
        SEL_PPOL = 4'h9
    } pgp_sel_e;

    // write channel progress, gray along idle -> addr/data -> resp
    typedef enum logic [1:0] {
        WS_IDLE = 2'b00,
        WS_ADDR = 2'b01,
        WS_RESP = 2'b11,
        WS_DATA = 2'b10
    } pgp_wstate_e;
endpackage

// [logic/pgp_port.sv]
// Purpose: register logic for an 8-pin analog-capable gpio port and a 2-pin edge flag pair
// Assumes: single bus clock, asynchronous active-low reset, axi4-lite register access
// Notes: pin levels pass a two-flop synchroniser before readback and edge detection
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ns
module pgp_port (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [pgp_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [pgp_pkg::DATA_W-1:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [pgp_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [pgp_pkg::DATA_W-1:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [pgp_pkg::PORT_W-1:0] pad_i,
    output logic [pgp_pkg::PORT_W-1:0] pad_o,
    output logic [pgp_pkg::PORT_W-1:0] pad_oe_o,
    output logic [pgp_pkg::PORT_W-1:0] pad_reduced_drive_o,
    output logic [pgp_pkg::PORT_W-1:0] pad_pull_en_o,
    output logic [pgp_pkg::PORT_W-1:0] pad_pull_down_o,
    input wire logic [pgp_pkg::PORT_W-1:0] periph_own_i,
    input wire logic [pgp_pkg::PORT_W-1:0] periph_oe_i,
    input wire logic [pgp_pkg::PORT_W-1:0] periph_out_i,
    output logic [pgp_pkg::PORT_W-1:0] periph_in_o,
    input wire logic [pgp_pkg::PORT_W-1:0] analog_converter_en_i,
    input wire logic [pgp_pkg::EDGE_W-1:0] edge_pin_i,
    output logic irq_o
);
    import pgp_pkg::*;

    logic [PORT_W-1:0] data_r;
    logic [PORT_W-1:0] dir_r;
    logic [PORT_W-1:0] drv_r;
    logic [PORT_W-1:0] pen_r;
    logic [PORT_W-1:0] ppol_r;
    logic [EDGE_W-1:0] epol_r;
    logic [EDGE_W-1:0] eien_r;
    logic [EDGE_W-1:0] flag_r;
    logic [EDGE_W-1:0] flag_nxt;
    logic [PORT_W-1:0] pin_s1_r;
    logic [PORT_W-1:0] pin_s2_r;
    logic [EDGE_W-1:0] epin_s1_r;
    logic [EDGE_W-1:0] epin_s2_r;
    logic [EDGE_W-1:0] epin_s3_r;
    logic [EDGE_W-1:0] edge_act;
    pgp_wstate_e wstate_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [PORT_W-1:0] wbyte_r;
    logic wlane_r;
    logic wr_fire;
    pgp_sel_e wsel;
    pgp_sel_e rsel;
    logic [PORT_W-1:0] rbyte;
    logic [EDGE_W-1:0] clr_mask;
    logic [PORT_W-1:0] oe_nxt;

    // maps a byte address onto a register select
    function automatic pgp_sel_e decode(input logic [ADDR_W-1:0] addr);
        logic [5:0] idx;
        idx = addr[ADDR_W-1:IDX_LSB];
        if (addr[IDX_LSB-1:0] != 2'b00) begin
            decode = SEL_NONE;
        end else begin
            case (idx)
                IDX_EDGE_POLARITY: decode = SEL_EPOL;
                IDX_EDGE_IRQ_EN: decode = SEL_EIEN;
                IDX_EDGE_FLAG: decode = SEL_EFLG;
                IDX_PORT_DATA: decode = SEL_DATA;
                IDX_PIN_LEVEL: decode = SEL_PINL;
                IDX_DIRECTION: decode = SEL_DIR;
                IDX_DRIVE: decode = SEL_DRV;
                IDX_PULL_EN: decode = SEL_PEN;
                IDX_PULL_POL: decode = SEL_PPOL;
                default: decode = SEL_NONE;
            endcase
        end
    endfunction

    // pin synchronisers; first stage feeds only the second
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_s1_r <= RST_BYTE;
            pin_s2_r <= RST_BYTE;
            epin_s1_r <= RST_EDGE;
            epin_s2_r <= RST_EDGE;
            epin_s3_r <= RST_EDGE;
        end else begin
            pin_s1_r <= pad_i;
            pin_s2_r <= pin_s1_r;
            epin_s1_r <= edge_pin_i;
            epin_s2_r <= epin_s1_r;
            epin_s3_r <= epin_s2_r;
        end
    end

    // rising when polarity set, falling otherwise
    assign edge_act = (epol_r & epin_s2_r & ~epin_s3_r)
        | (~epol_r & ~epin_s2_r & epin_s3_r);

    // write channel: address and data accepted in either order
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wstate_r <= WS_IDLE;
            awaddr_r <= '0;
            wbyte_r <= RST_BYTE;
            wlane_r <= 1'b0;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                awaddr_r <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                wbyte_r <= s_axi_wdata_i[PORT_W-1:0];
                wlane_r <= s_axi_wstrb_i[0];
            end
            case (wstate_r)
                WS_IDLE: begin
                    if (s_axi_awvalid_i && s_axi_wvalid_i) begin
                        wstate_r <= WS_RESP;
                    end else if (s_axi_awvalid_i) begin
                        wstate_r <= WS_ADDR;
                    end else if (s_axi_wvalid_i) begin
                        wstate_r <= WS_DATA;
                    end
                end
                WS_ADDR: begin
                    if (s_axi_wvalid_i) begin
                        wstate_r <= WS_RESP;
                    end
                end
                WS_DATA: begin
                    if (s_axi_awvalid_i) begin
                        wstate_r <= WS_RESP;
                    end
                end
                WS_RESP: begin
                    if (s_axi_bvalid_o && s_axi_bready_i) begin
                        wstate_r <= WS_IDLE;
                    end
                end
                default: wstate_r <= WS_IDLE;
            endcase
        end
    end

    assign s_axi_awready_o = (wstate_r == WS_IDLE) || (wstate_r == WS_DATA);
    assign s_axi_wready_o = (wstate_r == WS_IDLE) || (wstate_r == WS_ADDR);

    // the write lands one cycle after both halves are held, on the same edge that raises bvalid
    logic wr_pend_r;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_pend_r <= 1'b0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OKAY;
        end else begin
            wr_pend_r <= ((wstate_r == WS_IDLE) && s_axi_awvalid_i && s_axi_wvalid_i)
                || ((wstate_r == WS_ADDR) && s_axi_wvalid_i)
                || ((wstate_r == WS_DATA) && s_axi_awvalid_i);
            if (wr_fire) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    assign wr_fire = wr_pend_r;
    assign wsel = decode(awaddr_r);

    // configuration registers take writes at any time
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            data_r <= RST_BYTE;
            dir_r <= RST_BYTE;
            drv_r <= RST_BYTE;
            pen_r <= RST_BYTE;
            ppol_r <= RST_BYTE;
            epol_r <= RST_EDGE;
            eien_r <= RST_EDGE;
        end else if (wr_fire && wlane_r) begin
            case (wsel)
                SEL_DATA: data_r <= wbyte_r;
                SEL_DIR: dir_r <= wbyte_r;
                SEL_DRV: drv_r <= wbyte_r;
                SEL_PEN: pen_r <= wbyte_r;
                SEL_PPOL: ppol_r <= wbyte_r;
                SEL_EPOL: epol_r <= wbyte_r[EDGE_LSB +: EDGE_W];
                SEL_EIEN: eien_r <= wbyte_r[EDGE_LSB +: EDGE_W];
                default: data_r <= data_r;
            endcase
        end
    end

    // sticky edge flags, write one to clear, set wins
    assign clr_mask = (wr_fire && wlane_r && wsel == SEL_EFLG)
        ? wbyte_r[EDGE_LSB +: EDGE_W] : RST_EDGE;
    assign flag_nxt = (flag_r & ~clr_mask) | edge_act;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flag_r <= RST_EDGE;
            irq_o <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
            irq_o <= |(flag_r & eien_r);
        end
    end

    // read channel: one read in flight, answer one cycle after address
    assign rsel = decode(s_axi_araddr_i);
    always_comb begin
        rbyte = RST_BYTE;
        case (rsel)
            SEL_DATA: rbyte = (dir_r & data_r) | (~dir_r & pin_s2_r);
            SEL_PINL: rbyte = pin_s2_r;
            SEL_DIR: rbyte = dir_r;
            SEL_DRV: rbyte = drv_r;
            SEL_PEN: rbyte = pen_r;
            SEL_PPOL: rbyte = ppol_r;
            SEL_EPOL: rbyte[EDGE_LSB +: EDGE_W] = epol_r;
            SEL_EIEN: rbyte[EDGE_LSB +: EDGE_W] = eien_r;
            SEL_EFLG: rbyte[EDGE_LSB +: EDGE_W] = flag_r;
            default: rbyte = RST_BYTE;
        endcase
    end

    assign s_axi_arready_o = !s_axi_rvalid_o;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= '0;
            s_axi_rresp_o <= RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= {{(DATA_W-PORT_W){1'b0}}, rbyte};
            s_axi_rresp_o <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    // pad control; a peripheral that owns the pin overrides direction and data
    assign oe_nxt = (periph_own_i & periph_oe_i) | (~periph_own_i & dir_r);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pad_o <= RST_BYTE;
            pad_oe_o <= RST_BYTE;
            pad_reduced_drive_o <= RST_BYTE;
            pad_pull_en_o <= RST_BYTE;
            pad_pull_down_o <= RST_BYTE;
            periph_in_o <= RST_BYTE;
        end else begin
            pad_oe_o <= oe_nxt;
            pad_o <= (periph_own_i & periph_out_i) | (~periph_own_i & data_r);
            pad_reduced_drive_o <= oe_nxt & drv_r;
            pad_pull_en_o <= ~oe_nxt & pen_r & ~analog_converter_en_i;
            pad_pull_down_o <= ~oe_nxt & pen_r & ~analog_converter_en_i & ppol_r;
            periph_in_o <= pin_s2_r;
        end
    end

    flag_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        edge_act[0] |=> flag_r[0])
        else $error("edge did not set flag 0");

    flag_pol_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        $rose(epin_s2_r[1]) && epol_r[1] |-> edge_act[1])
        else $error("rising edge missed with polarity one");

    flag_clear_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        clr_mask[1] && !edge_act[1] |=> !flag_r[1])
        else $error("write one did not clear flag 1");

    set_wins_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        clr_mask[0] && edge_act[0] |=> flag_r[0])
        else $error("clear beat a same-cycle edge");

    irq_level_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ##1 irq_o == |($past(flag_r) & $past(eien_r)))
        else $error("interrupt does not follow enabled flags");

    irq_mask_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        eien_r == RST_EDGE && $stable(eien_r) |=> !irq_o)
        else $error("masked flag raised interrupt");

    data_read_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_axi_arvalid_i && s_axi_arready_o && rsel == SEL_DATA |=>
        s_axi_rdata_o[PORT_W-1:0] == (($past(dir_r) & $past(data_r))
        | (~$past(dir_r) & $past(pin_s2_r))))
        else $error("data read mixes wrong sources");

    pin_read_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ##2 pin_s2_r == $past(pad_i, 2))
        else $error("pin level lags more than two cycles");

    pad_dir_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ##1 pad_oe_o == (($past(periph_own_i) & $past(periph_oe_i))
        | (~$past(periph_own_i) & $past(dir_r))))
        else $error("pad enable ignores owner or direction");

    drive_out_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (pad_reduced_drive_o & ~pad_oe_o) == RST_BYTE)
        else $error("reduced drive on an input");

    pull_input_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (pad_pull_en_o & pad_oe_o) == RST_BYTE)
        else $error("pull enabled on an output");

    pull_analog_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ##1 (pad_pull_en_o & $past(analog_converter_en_i)) == RST_BYTE)
        else $error("pull enabled on analog channel");

    pull_reset_a: assert property (@(posedge clk_i)
        $rose(resetn_i) |-> pad_pull_en_o == RST_BYTE && pen_r == RST_BYTE)
        else $error("pull device active after reset");

    data_pin_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ##1 (pad_o & ~$past(periph_own_i)) == ($past(data_r) & ~$past(periph_own_i)))
        else $error("pad value differs from data register");

    cfg_write_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        wr_fire && wlane_r && wsel == SEL_PEN |=> pen_r == $past(wbyte_r))
        else $error("pull enable write not taken");

    pull_pol_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (pad_pull_down_o & ~pad_pull_en_o) == RST_BYTE)
        else $error("pull-down selected without pull enable");

    pin_level_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        s_axi_arvalid_i && s_axi_arready_o && rsel == SEL_PINL |=>
        s_axi_rdata_o[PORT_W-1:0] == $past(pin_s2_r))
        else $error("pin level read differs from pins");

    cov_irq_c: cover property (@(posedge clk_i) disable iff (!resetn_i) $rose(irq_o));
    cov_clear_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
        flag_r[0] ##1 clr_mask[0] ##1 !flag_r[0]);
    cov_both_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
        clr_mask[1] && edge_act[1]);
    cov_read_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
        s_axi_rvalid_o && s_axi_rready_i && s_axi_rresp_o == RESP_OKAY);
    cov_pull_dn_c: cover property (@(posedge clk_i) disable iff (!resetn_i)
        |pad_pull_down_o);
endmodule

// [tb/pgp_pin_model.sv]
// Purpose: board side of the analog port: resolves each pad from all its drivers
// Assumes: pads are three-state; an external source may drive an input pad
// Notes: an undriven pad without pull shows a pattern that changes every cycle
`timescale 1ns/1ns
module pgp_pin_model (
    input wire logic clk_i,
    input wire logic [7:0] pad_o_i,
    input wire logic [7:0] pad_oe_i,
    input wire logic [7:0] pull_en_i,
    input wire logic [7:0] pull_down_i,
    input wire logic [7:0] ext_en_i,
    input wire logic [7:0] ext_val_i,
    output logic [7:0] pad_level_o
);
    logic [7:0] float_r = 8'h55;
    always @(posedge clk_i) begin
        float_r <= ~float_r;
    end
    // module or peripheral drive wins, then outside source, then pull, else floating
    assign pad_level_o = (pad_oe_i & pad_o_i)
        | (~pad_oe_i & ext_en_i & ext_val_i)
        | (~pad_oe_i & ~ext_en_i & pull_en_i & ~pull_down_i)
        | (~pad_oe_i & ~ext_en_i & ~pull_en_i & float_r);
endmodule

// [tb/pgp_port_tb.sv]
// Purpose: self-checking bench for the analog port and edge flag register block
// Assumes: axi4-lite master tasks, pads resolved by the pin model
// Notes: waits after pin changes cover the synchroniser and register stages
`timescale 1ns/1ns
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin failures++; \
    $display("Error t=%0t got=%h exp=%h", $time, got, exp); end end
module pgp_port_tb;
    import pgp_pkg::*;
    logic clk_i = 0;
    logic resetn_i = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rd;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, rsp, edge_pin = 0;
    logic [31:0] rdata;
    logic [7:0] pad_lvl, pad_o, pad_oe, rdrv, pen, pdn, pin_in;
    logic [7:0] own = 0, poe = 0, pout = 0, ana = 0, ext_en = 8'hFF, ext_val = 0;
    int failures = 0, n_checks = 0, cycles = 0;
    always #50 clk_i = ~clk_i;
    pgp_port dut (.clk_i(clk_i), .resetn_i(resetn_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .pad_i(pad_lvl), .pad_o(pad_o),
        .pad_oe_o(pad_oe), .pad_reduced_drive_o(rdrv), .pad_pull_en_o(pen),
        .pad_pull_down_o(pdn), .periph_own_i(own), .periph_oe_i(poe), .periph_out_i(pout),
        .periph_in_o(pin_in), .analog_converter_en_i(ana), .edge_pin_i(edge_pin),
        .irq_o(irq));
    pgp_pin_model pins (.clk_i(clk_i), .pad_o_i(pad_o), .pad_oe_i(pad_oe),
        .pull_en_i(pen), .pull_down_i(pdn), .ext_en_i(ext_en), .ext_val_i(ext_val),
        .pad_level_o(pad_lvl));
    task automatic test_done();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            test_done();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic ta, tw, tb, fin;
        fin = 0;
        @(posedge clk_i);
        awaddr <= a; wdata <= {24'h00_0000, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (!fin) begin
            @(negedge clk_i);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            rsp = bresp;
            @(posedge clk_i);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
            if (tb) begin
                bready <= 0;
                fin = 1;
            end
        end
        `CHK(rsp, er)
    endtask
    task automatic rdr(input logic [7:0] a);
        logic ta, tr, fin;
        fin = 0;
        @(posedge clk_i);
        araddr <= a; arvalid <= 1; rready <= 1;
        while (!fin) begin
            @(negedge clk_i);
            ta = arvalid && arready;
            tr = rvalid;
            rd = rdata;
            rsp = rresp;
            @(posedge clk_i);
            if (ta) arvalid <= 0;
            if (tr) begin
                rready <= 0;
                fin = 1;
            end
        end
    endtask
    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] e);
        rdr({idx, 2'b00});
        `CHK({rsp, rd}, {RESP_OKAY, 24'h00_0000, e})
    endtask
    task automatic t_reset();
        logic [5:0] ids[9] = '{IDX_EDGE_POLARITY, IDX_EDGE_IRQ_EN, IDX_EDGE_FLAG,
            IDX_PORT_DATA, IDX_PIN_LEVEL, IDX_DIRECTION, IDX_DRIVE, IDX_PULL_EN, IDX_PULL_POL};
        foreach (ids[i]) rd_chk(ids[i], RST_BYTE);
        `CHK({pen, pad_oe, irq}, 17'h0_0000)
    endtask
    task automatic t_dir_data();
        ext_val <= 8'h3C;
        wr({IDX_PORT_DATA, 2'b00}, 8'hA5, RESP_OKAY);
        wr({IDX_DIRECTION, 2'b00}, 8'h0F, RESP_OKAY);
        wr({IDX_PIN_LEVEL, 2'b00}, 8'hFF, RESP_OKAY);
        repeat (3) @(posedge clk_i);
        `CHK({pad_oe, pad_o & pad_oe}, 16'h0F05)
        rd_chk(IDX_PORT_DATA, 8'h35);
        rd_chk(IDX_PIN_LEVEL, 8'h35);
        `CHK(pin_in, 8'h35)
    endtask
    task automatic t_pulls();
        ext_en <= 8'h0F; ana <= 8'h03;
        wr({IDX_PULL_EN, 2'b00}, 8'hFF, RESP_OKAY);
        wr({IDX_PULL_POL, 2'b00}, 8'hC0, RESP_OKAY);
        wr({IDX_DRIVE, 2'b00}, 8'hFF, RESP_OKAY);
        repeat (3) @(posedge clk_i);
        `CHK(pen, 8'hF0)
        `CHK(pdn & pen, 8'hC0)
        `CHK(rdrv & pad_oe, 8'h0F)
        ana <= 8'hF3;
        repeat (3) @(posedge clk_i);
        `CHK(pen, 8'h00)
        ana <= 8'h03;
        repeat (4) @(posedge clk_i);
        rd_chk(IDX_PIN_LEVEL, 8'h35);
    endtask
    task automatic t_periph();
        own <= 8'h81; poe <= 8'h80; pout <= 8'hFF;
        repeat (3) @(posedge clk_i);
        `CHK({pad_oe, pad_o[7]}, 9'h11D)
        wr({IDX_DIRECTION, 2'b00}, 8'h00, RESP_OKAY);
        repeat (3) @(posedge clk_i);
        `CHK(pad_oe, 8'h80)
        own <= 8'h00;
    endtask
    task automatic t_edges();
        wr({IDX_EDGE_POLARITY, 2'b00}, 8'h80, RESP_OKAY);
        edge_pin <= 2'b11;
        repeat (6) @(posedge clk_i);
        rd_chk(IDX_EDGE_FLAG, 8'h80);
        `CHK(irq, 1'b0)
        wr({IDX_EDGE_IRQ_EN, 2'b00}, 8'h80, RESP_OKAY);
        repeat (2) @(posedge clk_i);
        `CHK(irq, 1'b1)
        edge_pin <= 2'b10;
        repeat (6) @(posedge clk_i);
        rd_chk(IDX_EDGE_FLAG, 8'hC0);
        wr({IDX_EDGE_FLAG, 2'b00}, 8'h40, RESP_OKAY);
        rd_chk(IDX_EDGE_FLAG, 8'h80);
        wr({IDX_EDGE_FLAG, 2'b00}, 8'h80, RESP_OKAY);
        repeat (2) @(posedge clk_i);
        `CHK(irq, 1'b0)
        rd_chk(IDX_EDGE_FLAG, 8'h00);
    endtask
    task automatic t_unmapped();
        rdr(8'h00);
        `CHK({rsp, rd}, {RESP_SLVERR, 32'h0000_0000})
        wr(8'hC1, 8'hFF, RESP_SLVERR);
        wr({IDX_DIRECTION, 2'b00}, 8'hFF, RESP_OKAY);
        rd_chk(IDX_PORT_DATA, 8'hA5);
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        resetn_i <= 1;
        t_reset();
        t_dir_data();
        t_pulls();
        t_periph();
        t_edges();
        t_unmapped();
        test_done();
    end
endmodule
